/* File: rtl/remu_top.sv */
// Contract
// - Switching mask bit 7 set stops regulator 1 power-good invalid interrupt.
// - Switching mask bit 6, reset one, stops regulator 1 power-good valid interrupt.
// - Switching mask bit 4, reset zero, stops regulator 1 current-limit interrupt.
// - Switching mask bit 3, reset one, stops regulator 0 power-good invalid interrupt.
// - Switching mask bit 2, reset one, stops regulator 0 power-good valid interrupt.
// - Switching mask bit 0, reset zero, stops regulator 0 current-limit interrupt.
// - Masks gate only events; raw status bits always show the live condition.
// - Linear mask register at 0x23, same field layout, bits 5 and 1 reserved.
// - Linear mask bit 7, reset one, stops regulator 1 power-good invalid interrupt.
// - Linear mask bit 6, reset one, stops regulator 1 power-good valid interrupt.
// - Linear mask bit 4, reset zero, stops regulator 1 current-limit interrupt.
// - Linear mask bit 3, reset one, stops regulator 0 power-good invalid interrupt.
// - Linear mask bit 2, reset one, stops regulator 0 power-good valid interrupt.
// - Linear mask bit 0 set stops regulator 0 current-limit interrupt.
// - Switching mask register sits at address 0x22.
// - Linear raw power-good bit reads zero when valid, one when invalid, unlatched.
//
// Top of the regulator event mask unit: the two mask registers on the device's
// register port and four regulator channels. Assumes a single-cycle register port
// driven from the serial interface logic on ref_clk_i.
`timescale 1ns/1ps

module remu_top
#(
  parameter int NUM_REG = remu_pkg::NUM_REG
)
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        ce_i,
  input  wire logic [remu_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [remu_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [remu_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic [NUM_REG-1:0]          sw_pg_invalid_i,
  input  wire logic [NUM_REG-1:0]          sw_ilim_i,
  input  wire logic [NUM_REG-1:0]          lin_pg_invalid_i,
  input  wire logic [NUM_REG-1:0]          lin_ilim_i,
  output logic      [NUM_REG-1:0]          sw_pg_raw_o,
  output logic      [NUM_REG-1:0]          sw_ilim_raw_o,
  output logic      [NUM_REG-1:0]          lin_pg_raw_o,
  output logic      [NUM_REG-1:0]          lin_ilim_raw_o,
  output logic      [NUM_REG-1:0]          sw_pg_event_o,
  output logic      [NUM_REG-1:0]          sw_current_limit_event_o,
  output logic      [NUM_REG-1:0]          lin_pg_event_o,
  output logic      [NUM_REG-1:0]          lin_current_limit_event_o
);

  logic [remu_pkg::DATA_W-1:0] switching_regulator_event_mask;
  logic [remu_pkg::DATA_W-1:0] linear_regulator_event_mask;
  logic [remu_pkg::DATA_W-1:0] next_switching_regulator_event_mask;
  logic [remu_pkg::DATA_W-1:0] next_linear_regulator_event_mask;
  logic [remu_pkg::DATA_W-1:0] next_reg_rdata;
  logic [1:0]                  sw_pg_invalid_suppress;
  logic [1:0]                  sw_pg_valid_suppress;
  logic [1:0]                  sw_current_limit_suppress;
  logic [1:0]                  lin_pg_invalid_suppress;
  logic [1:0]                  lin_pg_valid_suppress;
  logic [1:0]                  lin_current_limit_suppress;

  // Register writes and reads. A read and a write in one cycle return the old value.
  always_comb
  begin
    next_switching_regulator_event_mask = switching_regulator_event_mask;
    next_linear_regulator_event_mask    = linear_regulator_event_mask;
    next_reg_rdata                      = reg_rdata_o;
    if (reg_wr_i && reg_addr_i == remu_pkg::SW_MASK_ADDR)
    begin
      next_switching_regulator_event_mask = reg_wdata_i & remu_pkg::MASK_WRITABLE;
    end
    if (reg_wr_i && reg_addr_i == remu_pkg::LIN_MASK_ADDR)
    begin
      next_linear_regulator_event_mask = reg_wdata_i & remu_pkg::MASK_WRITABLE;
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        remu_pkg::SW_MASK_ADDR:  next_reg_rdata = switching_regulator_event_mask;
        remu_pkg::LIN_MASK_ADDR: next_reg_rdata = linear_regulator_event_mask;
        default:                 next_reg_rdata = remu_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      switching_regulator_event_mask <= remu_pkg::SW_MASK_RESET;
      linear_regulator_event_mask    <= remu_pkg::LIN_MASK_RESET;
      reg_rdata_o                    <= remu_pkg::READ_ZERO;
    end
    else if (ce_i)
    begin
      switching_regulator_event_mask <= next_switching_regulator_event_mask;
      linear_regulator_event_mask    <= next_linear_regulator_event_mask;
      reg_rdata_o                    <= next_reg_rdata;
    end
  end

  // Each lane's suppress controls come straight from its mask fields.
  always_comb
  begin
    sw_pg_invalid_suppress[1]     = switching_regulator_event_mask[remu_pkg::REG1_PGF_BIT];
    sw_pg_valid_suppress[1]       = switching_regulator_event_mask[remu_pkg::REG1_PGR_BIT];
    sw_current_limit_suppress[1]  = switching_regulator_event_mask[remu_pkg::REG1_ILIM_BIT];
    sw_pg_invalid_suppress[0]     = switching_regulator_event_mask[remu_pkg::REG0_PGF_BIT];
    sw_pg_valid_suppress[0]       = switching_regulator_event_mask[remu_pkg::REG0_PGR_BIT];
    sw_current_limit_suppress[0]  = switching_regulator_event_mask[remu_pkg::REG0_ILIM_BIT];
    lin_pg_invalid_suppress[1]    = linear_regulator_event_mask[remu_pkg::REG1_PGF_BIT];
    lin_pg_valid_suppress[1]      = linear_regulator_event_mask[remu_pkg::REG1_PGR_BIT];
    lin_current_limit_suppress[1] = linear_regulator_event_mask[remu_pkg::REG1_ILIM_BIT];
    lin_pg_invalid_suppress[0]    = linear_regulator_event_mask[remu_pkg::REG0_PGF_BIT];
    lin_pg_valid_suppress[0]      = linear_regulator_event_mask[remu_pkg::REG0_PGR_BIT];
    lin_current_limit_suppress[0] = linear_regulator_event_mask[remu_pkg::REG0_ILIM_BIT];
  end

  // The field layout only holds two regulators per register, so lanes above one are unused.
  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    remu_channel u_sw
    (
      .ref_clk_i             (ref_clk_i),
      .srst_i                (srst_i),
      .ce_i                  (ce_i),
      .pg_invalid_i          (sw_pg_invalid_i[g]),
      .ilim_i                (sw_ilim_i[g]),
      .pg_invalid_suppress_i (sw_pg_invalid_suppress[g]),
      .pg_valid_suppress_i   (sw_pg_valid_suppress[g]),
      .ilim_suppress_i       (sw_current_limit_suppress[g]),
      .pg_raw_o              (sw_pg_raw_o[g]),
      .ilim_raw_o            (sw_ilim_raw_o[g]),
      .pg_event_o            (sw_pg_event_o[g]),
      .ilim_event_o          (sw_current_limit_event_o[g])
    );
    remu_channel u_lin
    (
      .ref_clk_i             (ref_clk_i),
      .srst_i                (srst_i),
      .ce_i                  (ce_i),
      .pg_invalid_i          (lin_pg_invalid_i[g]),
      .ilim_i                (lin_ilim_i[g]),
      .pg_invalid_suppress_i (lin_pg_invalid_suppress[g]),
      .pg_valid_suppress_i   (lin_pg_valid_suppress[g]),
      .ilim_suppress_i       (lin_current_limit_suppress[g]),
      .pg_raw_o              (lin_pg_raw_o[g]),
      .ilim_raw_o            (lin_ilim_raw_o[g]),
      .pg_event_o            (lin_pg_event_o[g]),
      .ilim_event_o          (lin_current_limit_event_o[g])
    );
  end

  a_mask_reset_value : assert property (
    @(posedge ref_clk_i)
    srst_i |=> switching_regulator_event_mask == remu_pkg::SW_MASK_RESET
            && linear_regulator_event_mask == remu_pkg::LIN_MASK_RESET)
    else $error("Mask registers missed their reset value.");

  a_reserved_read_zero : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (switching_regulator_event_mask & ~remu_pkg::MASK_WRITABLE) == remu_pkg::READ_ZERO
    && (linear_regulator_event_mask & ~remu_pkg::MASK_WRITABLE) == remu_pkg::READ_ZERO)
    else $error("Reserved mask bit became set.");

  a_sw_mask_write : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && reg_wr_i && reg_addr_i == remu_pkg::SW_MASK_ADDR
    |=> switching_regulator_event_mask == ($past(reg_wdata_i) & remu_pkg::MASK_WRITABLE))
    else $error("Switching mask write not stored.");

  a_lin_mask_write : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && reg_wr_i && reg_addr_i == remu_pkg::LIN_MASK_ADDR
    |=> linear_regulator_event_mask == ($past(reg_wdata_i) & remu_pkg::MASK_WRITABLE))
    else $error("Linear mask write not stored.");

  a_frozen_without_ce : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !ce_i |=> $stable(linear_regulator_event_mask) && $stable(reg_rdata_o))
    else $error("State changed while the clock enable was low.");

  a_sw_ilim_gated : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(sw_current_limit_event_o[0])
    |-> !$past(switching_regulator_event_mask[remu_pkg::REG0_ILIM_BIT]))
    else $error("Masked switching current-limit event escaped.");

  a_sw1_ilim_gated : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(sw_current_limit_event_o[1])
    |-> !$past(switching_regulator_event_mask[remu_pkg::REG1_ILIM_BIT]))
    else $error("Masked switching regulator 1 current-limit event escaped.");

  a_lin_ilim_gated : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(lin_current_limit_event_o[0])
    |-> !$past(linear_regulator_event_mask[remu_pkg::REG0_ILIM_BIT]))
    else $error("Masked linear current-limit event escaped.");

  a_lin_read_back : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && reg_rd_i && reg_addr_i == remu_pkg::LIN_MASK_ADDR
    |=> reg_rdata_o == $past(linear_regulator_event_mask))
    else $error("Linear mask read returned the wrong value.");

  a_unmapped_read : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && reg_rd_i && reg_addr_i != remu_pkg::SW_MASK_ADDR
    && reg_addr_i != remu_pkg::LIN_MASK_ADDR |=> reg_rdata_o == remu_pkg::READ_ZERO)
    else $error("Unmapped read did not return zero.");

  a_lin1_ilim_gated : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(lin_current_limit_event_o[1])
    |-> !$past(linear_regulator_event_mask[remu_pkg::REG1_ILIM_BIT]))
    else $error("Masked linear regulator 1 current-limit event escaped.");

  a_sw_read_back : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && reg_rd_i && reg_addr_i == remu_pkg::SW_MASK_ADDR
    |=> reg_rdata_o == $past(switching_regulator_event_mask))
    else $error("Switching mask read returned the wrong value.");

endmodule : remu_top

/* File: rtl/remu_pkg.sv */
// Constants for the regulator event mask unit: register offsets, field positions and resets.
// Assumes an 8-bit register address space reached through the device's serial register port.
package remu_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          NUM_REG     = 2;

  localparam logic [7:0]  SW_MASK_ADDR  = 8'h22;
  localparam logic [7:0]  LIN_MASK_ADDR = 8'h23;

  // Field positions within both mask registers.
  localparam int          REG1_PGF_BIT  = 7;
  localparam int          REG1_PGR_BIT  = 6;
  localparam int          REG1_ILIM_BIT = 4;
  localparam int          REG0_PGF_BIT  = 3;
  localparam int          REG0_PGR_BIT  = 2;
  localparam int          REG0_ILIM_BIT = 0;

  localparam logic [7:0]  SW_MASK_RESET  = 8'hCC;
  localparam logic [7:0]  LIN_MASK_RESET = 8'hCC;
  // Writable bits; the two reserved positions are excluded.
  localparam logic [7:0]  MASK_WRITABLE  = 8'hDD;
  localparam logic [7:0]  READ_ZERO      = 8'h00;

endpackage : remu_pkg

/* File: rtl/remu_channel.sv */
// One regulator's event detector: synchronises the raw power-good and current-limit
// levels and raises masked event pulses. Inputs arrive from the analog monitors, async.
`timescale 1ns/1ps

module remu_channel
(
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic pg_invalid_i,
  input  wire logic ilim_i,
  input  wire logic pg_invalid_suppress_i,
  input  wire logic pg_valid_suppress_i,
  input  wire logic ilim_suppress_i,
  output logic      pg_raw_o,
  output logic      ilim_raw_o,
  output logic      pg_event_o,
  output logic      ilim_event_o
);

  logic       pg_meta;
  logic       pg_sync;
  logic       ilim_meta;
  logic       ilim_sync;
  logic       next_pg_raw;
  logic       next_ilim_raw;
  logic       next_pg_event;
  logic       next_ilim_event;

  always_comb
  begin
    // Raw bits follow the live level regardless of any mask.
    next_pg_raw     = pg_sync;  // One means invalid, zero valid.
    next_ilim_raw   = ilim_sync;
    // Both directions feed one flag request, each gated by its own mask.
    next_pg_event   = (pg_sync & ~pg_raw_o & ~pg_invalid_suppress_i)
                    | (~pg_sync & pg_raw_o & ~pg_valid_suppress_i);
    next_ilim_event = ilim_sync & ~ilim_raw_o & ~ilim_suppress_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pg_meta      <= 1'b0;
      pg_sync      <= 1'b0;
      ilim_meta    <= 1'b0;
      ilim_sync    <= 1'b0;
      pg_raw_o     <= 1'b0;
      ilim_raw_o   <= 1'b0;
      pg_event_o   <= 1'b0;
      ilim_event_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pg_meta      <= pg_invalid_i;
      pg_sync      <= pg_meta;
      ilim_meta    <= ilim_i;
      ilim_sync    <= ilim_meta;
      pg_raw_o     <= next_pg_raw;
      ilim_raw_o   <= next_ilim_raw;
      pg_event_o   <= next_pg_event;
      ilim_event_o <= next_ilim_event;
    end
  end

  a_pg_unmasked_edge : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i && ((pg_sync && !pg_raw_o && !pg_invalid_suppress_i)
          || (!pg_sync && pg_raw_o && !pg_valid_suppress_i)) |=> pg_event_o)
    else $error("Unmasked power-good edge gave no event.");

  a_raw_follows_live : assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    ce_i |=> (pg_raw_o == $past(pg_sync)) && (ilim_raw_o == $past(ilim_sync)))
    else $error("Raw status did not follow the live level.");

endmodule : remu_channel

/* File: test/remu_host_model.sv */
// Host side of the register port: issues one-cycle write and read strobes.
// Assumes the unit takes a strobe at the edge and answers reads one cycle later.
`timescale 1ns/1ps

module remu_host_model
(
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Released address and data are inverted so that stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask : rd
endmodule : remu_host_model

/* File: test/regulator_event_mask_unit_bench.sv */
// Self-checking bench for the regulator event mask unit.
// Assumes the host model drives the register port; the bench drives monitor levels.
`timescale 1ns/1ps

module regulator_event_mask_unit_bench;
  logic       ref_clk_i;
  logic       srst_i;
  logic       ce_i;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] stim;
  wire  [7:0] ev;
  wire  [7:0] raw;
  int         fails;
  int         n_compared;

  remu_host_model host_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  remu_top dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .sw_pg_invalid_i(stim[1:0]), .sw_ilim_i(stim[3:2]),
    .lin_pg_invalid_i(stim[5:4]), .lin_ilim_i(stim[7:6]),
    .sw_pg_raw_o(raw[1:0]), .sw_ilim_raw_o(raw[3:2]),
    .lin_pg_raw_o(raw[5:4]), .lin_ilim_raw_o(raw[7:6]),
    .sw_pg_event_o(ev[1:0]), .sw_current_limit_event_o(ev[3:2]),
    .lin_pg_event_o(ev[5:4]), .lin_current_limit_event_o(ev[7:6]));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Counts pulses over a window wider than the sync latency, so no exact edge is assumed.
  task automatic step(input int i, input logic lvl, input logic pulse);
    int cnt;
    cnt = 0;
    @(posedge ref_clk_i);
    stim[i] <= lvl;
    repeat (8)
    begin
      @(posedge ref_clk_i);
      #1;
      if (ev[i] === 1'b1)
        cnt++;
      check(ev & ~(8'h01 << i), 8'h00);
    end
    check(8'(cnt), {7'h00, pulse});
    check({7'h00, raw[i]}, {7'h00, lvl});
  endtask : step

  task automatic test_regs;
    logic [7:0] rb;
    host_u.rd(remu_pkg::SW_MASK_ADDR, rb);
    check(rb, 8'hCC);
    host_u.rd(remu_pkg::LIN_MASK_ADDR, rb);
    check(rb, 8'hCC);
    host_u.rd(8'h24, rb);
    check(rb, 8'h00);
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    host_u.wr(remu_pkg::SW_MASK_ADDR, 8'h00);
    ce_i <= 1'b1;
    host_u.rd(remu_pkg::SW_MASK_ADDR, rb);
    check(rb, 8'hCC);
    host_u.wr(remu_pkg::LIN_MASK_ADDR, 8'hFF);
    host_u.wr(remu_pkg::SW_MASK_ADDR, 8'h22);
    host_u.rd(remu_pkg::LIN_MASK_ADDR, rb);
    check(rb, 8'hDD);
    host_u.rd(remu_pkg::SW_MASK_ADDR, rb);
    check(rb, 8'h00);
    $display("Test registers done");
  endtask : test_regs

  // Each mask bit gets its own on/off pattern over the runs, so a swapped field shows up.
  task automatic run_masks(input logic [7:0] sw_m, input logic [7:0] lin_m);
    logic [7:0] rb;
    logic [7:0] m;
    host_u.wr(remu_pkg::SW_MASK_ADDR, sw_m);
    host_u.wr(remu_pkg::LIN_MASK_ADDR, lin_m);
    host_u.rd(remu_pkg::SW_MASK_ADDR, rb);
    check(rb, sw_m & 8'hDD);
    host_u.rd(remu_pkg::LIN_MASK_ADDR, rb);
    check(rb, lin_m & 8'hDD);
    for (int d = 0; d < 2; d++)
      for (int r = 0; r < 2; r++)
      begin
        m = d ? lin_m : sw_m;
        step(d * 4 + r, 1'b1, ~m[r ? 7 : 3]);
        step(d * 4 + r, 1'b0, ~m[r ? 6 : 2]);
        step(d * 4 + 2 + r, 1'b1, ~m[r ? 4 : 0]);
        step(d * 4 + 2 + r, 1'b0, 1'b0);
      end
    $display("Test masks %h %h done", sw_m, lin_m);
  endtask : run_masks

  // A reset in mid-run must bring both masks and the read data back to their defaults.
  task automatic test_reset;
    logic [7:0] rb;
    host_u.wr(remu_pkg::SW_MASK_ADDR, 8'h00);
    host_u.wr(remu_pkg::LIN_MASK_ADDR, 8'h00);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    @(posedge ref_clk_i);
    srst_i <= 1'b0;
    #1;
    check(rdata, 8'h00);
    host_u.rd(remu_pkg::SW_MASK_ADDR, rb);
    check(rb, 8'hCC);
    host_u.rd(remu_pkg::LIN_MASK_ADDR, rb);
    check(rb, 8'hCC);
    $display("Test reset done");
  endtask : test_reset

  initial
  begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    stim = 8'h00;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    test_regs();
    run_masks(8'h00, 8'h00);
    run_masks(8'h94, 8'h94);
    run_masks(8'h51, 8'h8C);
    run_masks(8'h0D, 8'h81);
    run_masks(8'h00, 8'h5D);
    run_masks(8'hFF, 8'hFF);
    test_reset();
    stop_test();
  end
endmodule : regulator_event_mask_unit_bench
